// *** rtl/tcc_pkg.sv ***
package tcc_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [7:0] OFS_CTRL_A  = 8'h00;
    localparam logic [7:0] OFS_CTRL_B  = 8'h04;
    localparam logic [7:0] OFS_CNT_LO  = 8'h08;
    localparam logic [7:0] OFS_CNT_HI  = 8'h0c;
    localparam logic [7:0] OFS_CAP_LO  = 8'h10;
    localparam logic [7:0] OFS_CAP_HI  = 8'h14;
    localparam logic [7:0] OFS_FLAGS   = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h1c;
    localparam logic [7:0] OFS_CMP_CTL = 8'h20;
    localparam logic [7:0] OFS_NONE    = 8'hfc;
    // ==========================================================
    // field positions and masks
    localparam int         CS_LSB      = 0;
    localparam int         WGM_HI_LSB  = 3;
    localparam int         EDGE_BIT    = 6;
    localparam int         FILT_BIT    = 7;
    localparam logic [7:0] CTRL_A_MASK = 8'h03;
    localparam logic [7:0] CTRL_B_MASK = 8'hdf;
    localparam int         OVF_BIT     = 0;
    localparam int         CAP_BIT     = 1;
    localparam int         CMP_SEL_BIT = 0;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [2:0] HSIZE_WORD  = 3'b010;
    // ==========================================================
    // count values and clock selections
    localparam logic [15:0] VAL_BOTTOM = 16'h0000;
    localparam logic [15:0] VAL_MAX    = 16'hffff;
    localparam logic [15:0] TOP_8BIT   = 16'h00ff;
    localparam logic [15:0] TOP_9BIT   = 16'h01ff;
    localparam logic [15:0] TOP_10BIT  = 16'h03ff;
    localparam logic [2:0]  CS_STOP    = 3'h0;
    localparam logic [2:0]  CS_DIV1    = 3'h1;
    localparam logic [2:0]  CS_DIV8    = 3'h2;
    localparam logic [2:0]  CS_DIV64   = 3'h3;
    localparam logic [2:0]  CS_DIV256  = 3'h4;
    localparam logic [2:0]  CS_DIV1024 = 3'h5;
    localparam logic [2:0]  CS_EXT_FALL = 3'h6;
    localparam logic [2:0]  CS_EXT_RISE = 3'h7;
    localparam int          PRE_W      = 10;
    localparam int          FILT_LEN   = 4;
endpackage

// *** rtl/tcc_timer16.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcc_timer16
    import tcc_pkg::*;
#(
    parameter int FILT_N = FILT_LEN
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_clk_pin,
    input  wire logic        capture_pin,
    input  wire logic        comparator_output,
    input  wire logic        overflow_irq_ack,
    input  wire logic        capture_irq_ack,
    output logic             overflow_irq,
    output logic             capture_irq,
    output logic             count_at_top,
    output logic             count_at_bottom
);
    // ==========================================================
    // state
    logic              ph_valid_reg, ph_valid_next;
    logic              ph_write_reg, ph_write_next;
    logic [7:0]        ph_addr_reg, ph_addr_next;
    logic [31:0]       hrdata_reg, hrdata_next;
    logic [7:0]        ctrl_a_reg, ctrl_a_next;
    logic [7:0]        ctrl_b_reg, ctrl_b_next;
    logic [15:0]       cnt_reg, cnt_next;
    logic              dir_up_reg, dir_up_next;
    logic [7:0]        temp_reg, temp_next;
    logic [15:0]       cap_reg, cap_next;
    logic [1:0]        flags_reg, flags_next;
    logic [1:0]        irq_en_reg, irq_en_next;
    logic              cmp_sel_reg, cmp_sel_next;
    logic [PRE_W-1:0]  pre_reg, pre_next;
    logic [2:0]        sync1_reg, sync1_next;
    logic [2:0]        sync2_reg, sync2_next;
    logic [2:0]        sync3_reg, sync3_next;
    logic [2:0]        stable_reg, stable_next;
    logic              ext_prev_reg, ext_prev_next;
    logic [FILT_N-1:0] samp_reg, samp_next;
    logic              filt_reg, filt_next;
    logic              edge_prev_reg, edge_prev_next;

    logic        wr, rd, tick, updown, fast, icr_top, at_top, at_bottom;
    logic        ovf_event, cap_event, src, edge_in, cnt_wr;
    logic [3:0]  mode;
    logic [2:0]  cs;
    logic [7:0]  wd, rbyte;
    logic [15:0] top;

    // ==========================================================
    // bus slave: writes take effect at the end of the data phase;
    // reads add one wait state so a write just before is visible
    always_comb begin
        ph_valid_next = hsel && hready && htrans[1];
        ph_write_next = ph_write_reg;
        ph_addr_next  = ph_addr_reg;
        if (ph_valid_next) begin
            ph_write_next = hwrite;
            if (haddr[31:8] == 24'h0 && hsize == HSIZE_WORD) begin
                ph_addr_next = haddr[7:0];
            end else begin
                ph_addr_next = OFS_NONE;
            end
        end
    end

    assign wr        = ph_valid_reg && ph_write_reg;
    assign rd        = ph_valid_reg && !ph_write_reg;
    assign wd        = hwdata[7:0];
    assign hreadyout = !rd;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign cnt_wr    = wr && ph_addr_reg == OFS_CNT_LO;

    // ==========================================================
    // mode decode
    assign mode    = {ctrl_b_reg[WGM_HI_LSB +: 2], ctrl_a_reg[1:0]};
    assign cs      = ctrl_b_reg[CS_LSB +: 3];
    assign updown  = mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
    assign fast    = mode inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
    assign icr_top = mode inside {4'h8, 4'ha, 4'hc, 4'he};

    always_comb begin
        unique case (mode)
            4'h1, 4'h5:               top = TOP_8BIT;
            4'h2, 4'h6:               top = TOP_9BIT;
            4'h3, 4'h7:               top = TOP_10BIT;
            4'h8, 4'ha, 4'hc, 4'he:   top = cap_reg;
            default:                  top = VAL_MAX;
        endcase
    end

    assign at_top          = cnt_reg == top;
    assign at_bottom       = cnt_reg == VAL_BOTTOM;
    assign count_at_top    = at_top;
    assign count_at_bottom = at_bottom;

    // ==========================================================
    // timer tick: internal divider or synchronised external pin
    always_comb begin
        pre_next = pre_reg + PRE_W'(1);
        unique case (cs)
            CS_STOP:     tick = 1'b0;
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = &pre_reg[2:0];
            CS_DIV64:    tick = &pre_reg[5:0];
            CS_DIV256:   tick = &pre_reg[7:0];
            CS_DIV1024:  tick = &pre_reg[9:0];
            CS_EXT_FALL: tick = ext_prev_reg && !stable_reg[0];
            CS_EXT_RISE: tick = !ext_prev_reg && stable_reg[0];
        endcase
    end

    // ==========================================================
    // input sampling: bit 0 timer pin, 1 capture pin, 2 comparator;
    // the capture pin is sampled whatever drives it, so port
    // writes to that pin create capture events
    always_comb begin
        sync1_next = {comparator_output, capture_pin, ext_clk_pin};
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
        stable_next = (sync3_reg & ~(sync2_reg ^ sync3_reg))
                    | (stable_reg & (sync2_reg ^ sync3_reg));
        ext_prev_next = stable_reg[0];
        src = cmp_sel_reg ? stable_reg[2] : stable_reg[1];
        samp_next = {samp_reg[FILT_N-2:0], src};
        filt_next = filt_reg;
        if (samp_reg == {FILT_N{1'b1}}) begin
            filt_next = 1'b1;
        end else if (samp_reg == {FILT_N{1'b0}}) begin
            filt_next = 1'b0;
        end
        // filter runs on the system clock, not on the tick
        edge_in = ctrl_b_reg[FILT_BIT] ? filt_reg : src;
        edge_prev_next = edge_in;
        // capture-top modes would corrupt the top value
        cap_event = !icr_top && (ctrl_b_reg[EDGE_BIT]
                    ? (edge_in && !edge_prev_reg)
                    : (!edge_in && edge_prev_reg));
    end

    // ==========================================================
    // counter, latch, capture and software registers
    always_comb begin
        ctrl_a_next  = ctrl_a_reg;
        ctrl_b_next  = ctrl_b_reg;
        cnt_next     = cnt_reg;
        dir_up_next  = dir_up_reg;
        temp_next    = temp_reg;
        cap_next     = cap_reg;
        flags_next   = flags_reg;
        irq_en_next  = irq_en_reg;
        cmp_sel_next = cmp_sel_reg;
        hrdata_next  = hrdata_reg;
        rbyte        = RESET_BYTE;
        ovf_event    = 1'b0;

        if (tick) begin
            if (updown) begin
                dir_up_next = dir_up_reg ? !at_top : at_bottom;
                cnt_next = dir_up_next ? cnt_reg + 16'h1 : cnt_reg - 16'h1;
                ovf_event = at_bottom;
            end else begin
                dir_up_next = 1'b1;
                cnt_next = at_top ? VAL_BOTTOM : cnt_reg + 16'h1;
                ovf_event = fast ? at_top : cnt_reg == VAL_MAX;
            end
        end

        if (overflow_irq_ack) begin
            flags_next[OVF_BIT] = 1'b0;
        end
        if (capture_irq_ack) begin
            flags_next[CAP_BIT] = 1'b0;
        end

        if (wr) begin
            unique case (ph_addr_reg)
                OFS_CTRL_A:  ctrl_a_next = wd & CTRL_A_MASK;
                OFS_CTRL_B:  ctrl_b_next = wd & CTRL_B_MASK;
                // later assignment overrides any tick result
                OFS_CNT_LO:  cnt_next = {temp_reg, wd};
                OFS_CNT_HI:  temp_next = wd;
                OFS_CAP_LO: begin
                    if (icr_top) begin
                        cap_next = {temp_reg, wd};
                    end
                end
                OFS_CAP_HI:  temp_next = wd;
                OFS_FLAGS:   flags_next = flags_next & ~wd[1:0];
                OFS_IRQ_EN:  irq_en_next = wd[1:0];
                OFS_CMP_CTL: cmp_sel_next = wd[CMP_SEL_BIT];
                default: ;
            endcase
        end

        if (rd) begin
            unique case (ph_addr_reg)
                OFS_CTRL_A:  rbyte = ctrl_a_reg;
                OFS_CTRL_B:  rbyte = ctrl_b_reg;
                OFS_CNT_LO: begin
                    rbyte = cnt_reg[7:0];
                    temp_next = cnt_reg[15:8];
                end
                OFS_CNT_HI:  rbyte = temp_reg;
                OFS_CAP_LO: begin
                    rbyte = cap_reg[7:0];
                    temp_next = cap_reg[15:8];
                end
                OFS_CAP_HI:  rbyte = temp_reg;
                OFS_FLAGS:   rbyte = {6'h0, flags_reg};
                OFS_IRQ_EN:  rbyte = {6'h0, irq_en_reg};
                OFS_CMP_CTL: rbyte = {7'h0, cmp_sel_reg};
                default:     rbyte = RESET_BYTE;
            endcase
            hrdata_next = {24'h0, rbyte};
        end

        // hardware set wins over a clear in the same cycle
        if (ovf_event) begin
            flags_next[OVF_BIT] = 1'b1;
        end
        if (cap_event) begin
            cap_next = cnt_reg;
            flags_next[CAP_BIT] = 1'b1;
        end
    end

    assign overflow_irq = flags_reg[OVF_BIT] && irq_en_reg[OVF_BIT];
    assign capture_irq  = flags_reg[CAP_BIT] && irq_en_reg[CAP_BIT];

    // ==========================================================
    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_reg  <= 1'b0;
            ph_write_reg  <= 1'b0;
            ph_addr_reg   <= OFS_NONE;
            hrdata_reg    <= 32'h0;
            ctrl_a_reg    <= RESET_BYTE;
            ctrl_b_reg    <= RESET_BYTE;
            cnt_reg       <= VAL_BOTTOM;
            dir_up_reg    <= 1'b1;
            temp_reg      <= RESET_BYTE;
            cap_reg       <= VAL_BOTTOM;
            flags_reg     <= 2'h0;
            irq_en_reg    <= 2'h0;
            cmp_sel_reg   <= 1'b0;
            pre_reg       <= '0;
            sync1_reg     <= 3'h0;
            sync2_reg     <= 3'h0;
            sync3_reg     <= 3'h0;
            stable_reg    <= 3'h0;
            ext_prev_reg  <= 1'b0;
            samp_reg      <= '0;
            filt_reg      <= 1'b0;
            edge_prev_reg <= 1'b0;
        end else begin
            ph_valid_reg  <= ph_valid_next;
            ph_write_reg  <= ph_write_next;
            ph_addr_reg   <= ph_addr_next;
            hrdata_reg    <= hrdata_next;
            ctrl_a_reg    <= ctrl_a_next;
            ctrl_b_reg    <= ctrl_b_next;
            cnt_reg       <= cnt_next;
            dir_up_reg    <= dir_up_next;
            temp_reg      <= temp_next;
            cap_reg       <= cap_next;
            flags_reg     <= flags_next;
            irq_en_reg    <= irq_en_next;
            cmp_sel_reg   <= cmp_sel_next;
            pre_reg       <= pre_next;
            sync1_reg     <= sync1_next;
            sync2_reg     <= sync2_next;
            sync3_reg     <= sync3_next;
            stable_reg    <= stable_next;
            ext_prev_reg  <= ext_prev_next;
            samp_reg      <= samp_next;
            filt_reg      <= filt_next;
            edge_prev_reg <= edge_prev_next;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_cnt_lo_wr;
        wr && ph_addr_reg == OFS_CNT_LO;
    endsequence
    sequence s_cnt_lo_rd;
        rd && ph_addr_reg == OFS_CNT_LO;
    endsequence
    sequence s_hi_rd;
        rd && (ph_addr_reg == OFS_CNT_HI || ph_addr_reg == OFS_CAP_HI);
    endsequence
    sequence s_cap_lo_wr;
        wr && ph_addr_reg == OFS_CAP_LO;
    endsequence
    sequence s_cap_lo_rd;
        rd && ph_addr_reg == OFS_CAP_LO;
    endsequence

    cnt_lo_write_a: assert property (s_cnt_lo_wr |=>
        cnt_reg == {$past(temp_reg), $past(wd)})
        else $error("count low write did not load latch and byte");
    cnt_write_wins_a: assert property (s_cnt_lo_wr and tick |=>
        cnt_reg == {$past(temp_reg), $past(wd)})
        else $error("count operation overrode software write");
    cnt_lo_read_a: assert property (s_cnt_lo_rd |=>
        {temp_reg, hrdata[7:0]} == $past(cnt_reg) && hreadyout)
        else $error("count low read not coherent");
    hi_read_a: assert property (s_hi_rd |-> !hreadyout ##1
        (hrdata[7:0] == $past(temp_reg) && hreadyout))
        else $error("high byte read did not return latch");
    stop_hold_a: assert property (cs == CS_STOP && !cnt_wr |=>
        $stable(cnt_reg))
        else $error("counter moved with no clock source");
    up_count_a: assert property (tick && !updown && !at_top && !cnt_wr
        |=> cnt_reg == $past(cnt_reg) + 16'h1)
        else $error("counter did not increment");
    ovf_set_a: assert property (tick && !updown && !fast &&
        cnt_reg == VAL_MAX |=> flags_reg[OVF_BIT])
        else $error("overflow flag not set at max");
    cap_copy_a: assert property (cap_event |=>
        cap_reg == $past(cnt_reg) && flags_reg[CAP_BIT])
        else $error("capture copy or flag missing");
    cap_clear_a: assert property (capture_irq_ack && !cap_event |=>
        !flags_reg[CAP_BIT] && !capture_irq)
        else $error("capture flag not cleared on service");
    cap_guard_a: assert property (icr_top &&
        !(wr && ph_addr_reg == OFS_CAP_LO) |=> $stable(cap_reg))
        else $error("capture register changed in capture-top mode");
    filt_hold_a: assert property ($changed(filt_reg) |->
        $past(samp_reg) == {FILT_N{filt_reg}})
        else $error("filter output changed without four equal samples");
    ovf_clear_a: assert property (overflow_irq_ack && !ovf_event |=>
        !flags_reg[OVF_BIT] && !overflow_irq)
        else $error("overflow flag not cleared on service");
    ovf_set_wins_a: assert property (ovf_event |=> flags_reg[OVF_BIT])
        else $error("overflow flag lost to a clear");
    down_count_a: assert property (tick && updown && !dir_up_reg && !at_bottom &&
        !cnt_wr |=> cnt_reg == $past(cnt_reg) - 16'h1)
        else $error("counter did not decrement");
    top_turn_a: assert property (tick && updown && dir_up_reg && at_top &&
        !at_bottom && !cnt_wr |=> !dir_up_reg && cnt_reg == $past(cnt_reg) - 16'h1)
        else $error("counter did not turn at top");
    wrap_top_a: assert property (tick && !updown && at_top && !cnt_wr |=>
        cnt_reg == VAL_BOTTOM)
        else $error("counter did not wrap after top");
    cap_lo_drop_a: assert property (s_cap_lo_wr and (!icr_top && !cap_event) |=>
        $stable(cap_reg))
        else $error("capture register took a write outside capture-top modes");
    cap_lo_load_a: assert property (s_cap_lo_wr and icr_top |=>
        cap_reg == {$past(temp_reg), $past(wd)})
        else $error("capture top write did not load latch and byte");
    cap_top_off_a: assert property (icr_top |=> !$rose(flags_reg[CAP_BIT]))
        else $error("capture fired in capture-top mode");
    cap_lo_read_a: assert property (s_cap_lo_rd |=>
        {temp_reg, hrdata[7:0]} == $past(cap_reg))
        else $error("capture low read not coherent");
    sync_hold_a: assert property (sync2_reg != sync3_reg |=> $stable(stable_reg))
        else $error("pin level taken before two samples agreed");
endmodule // tcc_timer16
`default_nettype wire

// *** tb/tcc_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// far side: external clock, capture pin and comparator level
module tcc_far_model (
    input  wire logic hclk,
    output logic      ext_clk_pin,
    output logic      capture_pin,
    output logic      comparator_output
);
    initial begin
        ext_clk_pin       = 1'b0;
        capture_pin       = 1'b0;
        comparator_output = 1'b0;
    end

    // external clock idles low between bursts; 3-cycle phases survive the synchroniser
    task automatic ext_ticks(input int n);
        repeat (n) begin
            @(posedge hclk);
            ext_clk_pin <= 1'b1;
            repeat (3) @(posedge hclk);
            ext_clk_pin <= 1'b0;
            repeat (2) @(posedge hclk);
        end
    endtask

    // port-driven pin level, held for a number of clocks
    task automatic drive(input logic pin, input logic cmp, input int hold);
        @(posedge hclk);
        capture_pin       <= pin;
        comparator_output <= cmp;
        repeat (hold) @(posedge hclk);
    endtask
endmodule // tcc_far_model
`default_nettype wire

// *** tb/timer16_counter_and_capture_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module timer16_counter_and_capture_test;
    import tcc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, seen;
    logic [2:0]  hsize;
    logic        ov_ack, cap_ack, ov_irq, cap_irq, at_top, at_bot;
    logic        ext_clk, cap_pin, cmp_out;
    logic [7:0]  q;
    logic [15:0] v;
    int          error_cnt, n_tests;

    tcc_timer16 u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_clk_pin(ext_clk), .capture_pin(cap_pin), .comparator_output(cmp_out),
        .overflow_irq_ack(ov_ack), .capture_irq_ack(cap_ack), .overflow_irq(ov_irq),
        .capture_irq(cap_irq), .count_at_top(at_top), .count_at_bottom(at_bot));

    tcc_far_model u_far (.hclk(hclk), .ext_clk_pin(ext_clk), .capture_pin(cap_pin),
        .comparator_output(cmp_out));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (at_top === 1'b1) seen[0] <= 1'b1;
        if (at_bot === 1'b1) seen[1] <= 1'b1;
    end

    // ==========================================================
    // bus tasks and checks
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // on waking at an edge the bench still sees the value that edge sampled
    task automatic wait_rdy;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_rdy();
        q = hrdata[7:0];
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 8'h00);
    endtask

    task automatic wr16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] d);
        wr(hi, d[15:8]);
        wr(lo, d[7:0]);
    endtask

    task automatic rd16(input logic [7:0] lo, input logic [7:0] hi);
        rd(lo);
        v[7:0] = q;
        rd(hi);
        v[15:8] = q;
    endtask

    task automatic pulse(input logic ov);
        @(posedge hclk);
        if (ov) ov_ack <= 1'b1;
        else cap_ack <= 1'b1;
        @(posedge hclk);
        ov_ack  <= 1'b0;
        cap_ack <= 1'b0;
        @(negedge hclk);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        $display("[ERR] watchdog expected done seen hang");
        stop_test();
    end

    // ==========================================================
    // test sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b1; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
        hsize = HSIZE_WORD; hwdata = '0; ov_ack = 1'b0; cap_ack = 1'b0; seen = 2'b00;
        error_cnt = 0; n_tests = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("bottom_rst", at_bot, 1);
        rd(OFS_CTRL_B);
        chk("ctrl_b_rst", q, RESET_BYTE);
        wr(OFS_CTRL_B, 8'hff);
        rd(OFS_CTRL_B);
        chk("ctrl_b_mask", q, CTRL_B_MASK);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_NONE, 8'hff);
        rd(OFS_NONE);
        chk("unmapped", q, 0);
        chk("hresp_okay", hresp, 0);
        $display("test registers done");

        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h1234);
        repeat (20) @(posedge hclk);
        rd16(OFS_CNT_LO, OFS_CNT_HI);
        chk("cnt_stopped", v, 16'h1234);
        wr(OFS_CNT_HI, 8'h77);
        rd(OFS_CNT_HI);
        chk("hi_is_latch", q, 8'h77);
        rd(OFS_CNT_LO);
        wr(OFS_CNT_LO, 8'h00);
        rd16(OFS_CNT_LO, OFS_CNT_HI);
        chk("low_read_latch", v, 16'h1200);
        $display("test latch done");

        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'hfff8);
        wr(OFS_FLAGS, 8'h03);
        seen <= 2'b00;
        wr(OFS_CTRL_B, {5'h0, CS_DIV1});
        repeat (20) @(posedge hclk);
        wr(OFS_CTRL_B, 8'h00);
        rd(OFS_FLAGS);
        chk("ovf_flag", q[OVF_BIT], 1);
        chk("top_bottom", seen, 2'b11);
        wr(OFS_IRQ_EN, 8'h01);
        @(negedge hclk);
        chk("ovf_irq", ov_irq, 1);
        pulse(1'b1);
        chk("ovf_ack", ov_irq, 0);
        @(posedge hclk);
        wr(OFS_CTRL_B, {5'h0, CS_DIV1});
        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'habcd);
        wr(OFS_CTRL_B, 8'h00);
        rd16(OFS_CNT_LO, OFS_CNT_HI);
        chk("write_wins", (v - 16'habcd) < 16'd8, 1);
        $display("test count done");

        wr(OFS_CTRL_A, 8'h01);
        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h00f0);
        wr(OFS_CTRL_B, {5'h0, CS_DIV1});
        repeat (40) @(posedge hclk);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_CTRL_A, 8'h00);
        rd16(OFS_CNT_LO, OFS_CNT_HI);
        chk("updown_top", v[15:8], 0);
        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h0000);
        wr(OFS_CTRL_B, {5'h0, CS_EXT_RISE});
        u_far.ext_ticks(5);
        repeat (6) @(posedge hclk);
        wr(OFS_CTRL_B, 8'h00);
        rd16(OFS_CNT_LO, OFS_CNT_HI);
        chk("ext_ticks", v, 16'h0005);
        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h0000);
        wr(OFS_CTRL_B, {5'h0, CS_EXT_FALL});
        u_far.ext_ticks(3);
        repeat (6) @(posedge hclk);
        wr(OFS_CTRL_B, 8'h00);
        rd16(OFS_CNT_LO, OFS_CNT_HI);
        chk("ext_fall_ticks", v, 16'h0003);
        $display("test modes done");

        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h1234);
        wr(OFS_CTRL_B, 8'h40);
        wr(OFS_FLAGS, 8'h03);
        wr(OFS_IRQ_EN, 8'h02);
        u_far.drive(1'b1, 1'b0, 12);
        rd(OFS_FLAGS);
        chk("cap_flag", q[CAP_BIT], 1);
        chk("cap_irq", cap_irq, 1);
        rd16(OFS_CAP_LO, OFS_CAP_HI);
        chk("cap_value", v, 16'h1234);
        wr(OFS_FLAGS, 8'h02);
        @(negedge hclk);
        chk("cap_w1c", cap_irq, 0);
        @(posedge hclk);
        wr(OFS_CTRL_B, 8'h00);
        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h0abc);
        wr(OFS_FLAGS, 8'h03);
        u_far.drive(1'b0, 1'b0, 12);
        rd16(OFS_CAP_LO, OFS_CAP_HI);
        chk("cap_falling", v, 16'h0abc);
        pulse(1'b0);
        chk("cap_ack", cap_irq, 0);
        u_far.drive(1'b1, 1'b0, 12);
        rd(OFS_FLAGS);
        chk("wrong_edge", q[CAP_BIT], 0);
        $display("test capture done");

        wr(OFS_CMP_CTL, 8'h01);
        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h0777);
        wr(OFS_CTRL_B, 8'h40);
        wr(OFS_FLAGS, 8'h03);
        u_far.drive(1'b0, 1'b1, 12);
        rd16(OFS_CAP_LO, OFS_CAP_HI);
        chk("cap_cmp", v, 16'h0777);
        wr(OFS_CMP_CTL, 8'h00);
        wr(OFS_CTRL_B, 8'hc0);
        wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h0999);
        wr(OFS_FLAGS, 8'h03);
        u_far.drive(1'b1, 1'b0, 2);
        u_far.drive(1'b0, 1'b0, 12);
        rd(OFS_FLAGS);
        chk("filt_glitch", q[CAP_BIT], 0);
        u_far.drive(1'b1, 1'b0, 16);
        rd16(OFS_CAP_LO, OFS_CAP_HI);
        chk("filt_pass", v, 16'h0999);
        $display("test source and filter done");

        wr16(OFS_CAP_HI, OFS_CAP_LO, 16'h0055);
        rd16(OFS_CAP_LO, OFS_CAP_HI);
        chk("cap_ro", v, 16'h0999);
        wr(OFS_CTRL_B, 8'h58);
        wr16(OFS_CAP_HI, OFS_CAP_LO, 16'h0010);
        rd16(OFS_CAP_LO, OFS_CAP_HI);
        chk("cap_top_wr", v, 16'h0010);
        wr(OFS_CNT_HI, 8'h03);
        wr(OFS_CNT_LO, 8'h11);
        wr(OFS_CAP_LO, 8'h22);
        rd16(OFS_CNT_LO, OFS_CNT_HI);
        chk("latch_reuse_cnt", v, 16'h0311);
        rd16(OFS_CAP_LO, OFS_CAP_HI);
        chk("latch_reuse_cap", v, 16'h0322);
        wr(OFS_FLAGS, 8'h03);
        u_far.drive(1'b0, 1'b0, 4);
        u_far.drive(1'b1, 1'b0, 16);
        rd(OFS_FLAGS);
        chk("cap_top_off", q[CAP_BIT], 0);
        $display("test capture top done");
        stop_test();
    end
endmodule // timer16_counter_and_capture_test
`default_nettype wire
